// ---- common/isa_port_pkg.sv ----
// constants and types for the cpu-side address and byte-enable port
// assumes one 250 MHz clock and inputs already synchronous to it
//
// Operation
// - A25/A24 driven in dma, master, refresh
// - A25/A24 from alt page; master drives low
// - A23-A2 outputs in dma, master, refresh
// - input A23-A2 forwarded to SA and LA
// - A15-A2 decoded for internal io registers
// - refresh drives page plus refresh counter
// - dma drives page plus dma address
// - master: A23-A17 from LA, A16-A2 from SA
// - byte enables outputs when driving; decoded inputs
// - driven byte enables derived from SA1/SA0/SBHE
// - strap high selects 16-bit A1/BHE/A0 pins
// - 16-bit A1 to SA1, driven from SA1
// - 16-bit BHE to SBHE, driven from SBHE
// - 16-bit A0 to SA0, driven from SA0
// - SA outputs hold when no valid access
// - refresh command puts refresh address on SA
// - dma spans 64 Mbyte via bits 25-24
// - hold ack low means cpu mode, inputs
// - master ignores SA17-SA19, LA used instead
// - cpu mode: block input forces LA20 low
package isa_port_pkg;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int ADDR_MSB       = 23;  // top of the bidirectional address field
  localparam int ADDR_LSB       = 2;
  localparam int LA_LSB         = 17;  // lowest latchable slot address bit
  localparam int LA_BLOCK_BIT   = 20;  // gated by the a20 block input
  localparam int IO_IDX_MSB     = 15;  // io register index field top
  localparam int SA_WIDTH       = 20;
  localparam int DMA_WIDTH      = 16;
  localparam int PAGE_WIDTH     = 8;
  localparam int REFRESH_WIDTH  = 9;   // refresh row counter width

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  BE_IDLE_N     = 4'hF;
  localparam logic [1:0]  ADDR_TOP_LOW  = 2'h0;
  localparam logic        STRAP_DEFAULT = 1'h1;  // pulled up: 16-bit mode

  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CPU,
    MODE_DMA,
    MODE_REFRESH,
    MODE_MASTER
  } mode_t;

endpackage : isa_port_pkg

// ---- common/be_xlate_if.sv ----
// carrier between the port top and its byte-enable translator
// assumes purely combinational use inside one clock domain
`timescale 1ns/100ps
interface be_xlate_if;
  logic       wide_mode;   // 1: four byte enables, 0: A1/BHE/A0
  logic [3:0] be_pin_n;    // sampled byte-enable pins
  logic       sa1_slot;    // slot SA1 input
  logic       sa0_slot;    // slot SA0 input
  logic       sbhe_slot_n; // slot SBHE input
  logic       sa1_cpu;     // decoded towards slot
  logic       sa0_cpu;
  logic       sbhe_cpu_n;
  logic [3:0] be_drive_n;  // value for the pins when driven

  modport xlate (
    input  wide_mode, be_pin_n, sa1_slot, sa0_slot, sbhe_slot_n,
    output sa1_cpu, sa0_cpu, sbhe_cpu_n, be_drive_n
  );
  modport user (
    output wide_mode, be_pin_n, sa1_slot, sa0_slot, sbhe_slot_n,
    input  sa1_cpu, sa0_cpu, sbhe_cpu_n, be_drive_n
  );
endinterface : be_xlate_if

// ---- verilog/be_xlate.sv ----
// byte-enable to SA1/SA0/SBHE translation in both directions
// assumes the caller registers every result before it reaches a pin
`timescale 1ns/100ps
module be_xlate
  import isa_port_pkg::*;
(
  be_xlate_if.xlate bus
);

  // ------------------------------------------------------------
  // pin to slot decode
  // ------------------------------------------------------------
  wire [3:0] be_on      = ~bus.be_pin_n;
  wire       low_half   = be_on[0] | be_on[1];
  // lowest enabled byte sets A1/A0; a word split starts low
  wire       wide_sa1   = ~low_half & (be_on[2] | be_on[3]);
  wire       wide_sa0   = low_half ? ~be_on[0] : ~be_on[2];
  wire       wide_sbhe  = low_half ? ~be_on[1] : ~be_on[3];

  // four byte enables decoded or 16-bit pins passed
  assign bus.sa1_cpu    = bus.wide_mode ? wide_sa1  : bus.be_pin_n[2];
  assign bus.sa0_cpu    = bus.wide_mode ? wide_sa0  : bus.be_pin_n[0];
  assign bus.sbhe_cpu_n = bus.wide_mode ? wide_sbhe : bus.be_pin_n[1];

  // ------------------------------------------------------------
  // slot to pin encode
  // ------------------------------------------------------------
  wire       lo_byte    = ~bus.sa0_slot;
  wire       hi_byte    = bus.sa0_slot | ~bus.sbhe_slot_n;
  wire [1:0] pair_on    = {hi_byte, lo_byte};
  wire [3:0] wide_be_n  = bus.sa1_slot ? ~{pair_on, 2'h0} : ~{2'h0, pair_on};
  wire [3:0] narrow_n   = {1'h1, bus.sa1_slot, bus.sbhe_slot_n, bus.sa0_slot};

  // pins driven from slot signals when they are outputs
  assign bus.be_drive_n = bus.wide_mode ? wide_be_n : narrow_n;

endmodule : be_xlate

// ---- verilog/isa_addr_port.sv ----
// cpu-side address and byte-enable port of the slot bus controller
// assumes all inputs synchronous to CLK_IN; pins resolved outside
`timescale 1ns/100ps
module isa_addr_port
  import isa_port_pkg::*;
(
  input  wire logic                   CLK_IN,
  input  wire logic                   RESET_N_IN,
  // mode selection
  input  wire logic                   HOLD_ACK_IN,
  input  wire logic                   BUS_MASTER_IN,
  input  wire logic                   REFRESH_CMD_IN,
  input  wire logic                   CPU_TYPE_STRAP_IN,
  input  wire logic                   GATE_A20_BLOCK_N_IN,
  input  wire logic                   BUS_VALID_IN,
  input  wire logic                   IO_CYCLE_IN,
  // local address pins
  input  wire logic [ADDR_MSB:ADDR_LSB] A_IN,
  output logic      [ADDR_MSB:ADDR_LSB] A_OUT,
  output logic                        A_OE_OUT,
  output logic      [1:0]             A_TOP_OUT,
  output logic                        A_TOP_OE_OUT,
  input  wire logic [3:0]             BE_N_IN,
  output logic      [3:0]             BE_N_OUT,
  output logic                        BE_OE_OUT,
  // page, dma and slot sources
  input  wire logic [PAGE_WIDTH-1:0]  PAGE_IN,
  input  wire logic [1:0]             ALT_PAGE_IN,
  input  wire logic [DMA_WIDTH-1:0]   DMA_ADDR_IN,
  input  wire logic [SA_WIDTH-1:0]    SA_IN,
  input  wire logic                   SBHE_N_IN,
  input  wire logic [ADDR_MSB:LA_LSB] LA_IN,
  // slot address outputs
  output logic      [SA_WIDTH-1:0]    SA_OUT,
  output logic                        SBHE_N_OUT,
  output logic                        SA_OE_OUT,
  output logic      [ADDR_MSB:LA_LSB] LA_OUT,
  output logic                        LA_OE_OUT,
  // internal io register select
  output logic      [IO_IDX_MSB-ADDR_LSB:0] IO_INDEX_OUT,
  output logic                        IO_SELECT_OUT
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  mode_t                         mode;
  mode_t                         next_mode;
  logic                          strap_taken;
  logic                          narrow_mode;
  logic [REFRESH_WIDTH-1:0]      refresh_cnt;
  logic [ADDR_MSB:ADDR_LSB]      next_a;
  logic [1:0]                    next_a_top;
  logic [SA_WIDTH-1:0]           next_sa;
  logic                          next_sbhe_n;
  logic [ADDR_MSB:LA_LSB]        next_la;
  logic [3:0]                    next_be_n;

  be_xlate_if xif ();

  be_xlate u_be_xlate (
    .bus (xif.xlate)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // hold ack low keeps the cpu in charge of the local bus
  wire in_hold       = HOLD_ACK_IN;
  wire pick_refresh  = in_hold & REFRESH_CMD_IN;
  wire pick_master   = in_hold & ~REFRESH_CMD_IN & BUS_MASTER_IN;

  wire refresh_mode  = (mode == MODE_REFRESH);
  wire next_drives   = (next_mode != MODE_CPU);

  // refresh over master over dma
  always_comb begin
    if (!in_hold) begin
      next_mode = MODE_CPU;
    end else if (pick_refresh) begin
      next_mode = MODE_REFRESH;
    end else if (pick_master) begin
      next_mode = MODE_MASTER;
    end else begin
      next_mode = MODE_DMA;
    end
  end

  // mode register, cpu mode out of reset
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode <= MODE_CPU;
    end else begin
      mode <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  // taken once after release; the strap is fixed during operation
  // high: A1/BHE/A0, low: four enables
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      strap_taken <= 1'h0;
      narrow_mode <= STRAP_DEFAULT;
    end else if (!strap_taken) begin
      strap_taken <= 1'h1;
      narrow_mode <= CPU_TYPE_STRAP_IN;
    end
  end

  // ------------------------------------------------------------
  // refresh address counter
  // ------------------------------------------------------------
  // advances once per refresh cycle, after its address went out
  // nine bits, wraps freely
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      refresh_cnt <= '0;
    end else if (refresh_mode && next_mode != MODE_REFRESH) begin
      refresh_cnt <= refresh_cnt + 1'h1;
    end
  end

  // ------------------------------------------------------------
  // byte-enable translator hookup
  // ------------------------------------------------------------
  assign xif.wide_mode   = ~narrow_mode;
  assign xif.be_pin_n    = BE_N_IN;
  assign xif.sa1_slot    = SA_IN[1];
  assign xif.sa0_slot    = SA_IN[0];
  assign xif.sbhe_slot_n = SBHE_N_IN;

  // ------------------------------------------------------------
  // source selection for every address field
  // ------------------------------------------------------------
  // page above the low address
  wire [DMA_WIDTH-1:0]  ref_addr  = {{(DMA_WIDTH-REFRESH_WIDTH){1'h0}}, refresh_cnt};
  wire [ADDR_MSB:ADDR_LSB] dma_a  = {PAGE_IN, DMA_ADDR_IN[DMA_WIDTH-1:ADDR_LSB]};
  wire [ADDR_MSB:ADDR_LSB] ref_a  = {PAGE_IN, ref_addr[DMA_WIDTH-1:ADDR_LSB]};
  // SA17-SA19 skipped; the master's LA lines carry those bits
  wire [ADDR_MSB:ADDR_LSB] mst_a  = {LA_IN, SA_IN[LA_LSB-1:ADDR_LSB]};

  // slot values per mode
  wire [SA_WIDTH-1:0]   cpu_sa    = {A_IN[SA_WIDTH-1:ADDR_LSB], xif.sa1_cpu, xif.sa0_cpu};
  wire [SA_WIDTH-1:0]   dma_sa    = {PAGE_IN[3:0], DMA_ADDR_IN};
  wire [SA_WIDTH-1:0]   ref_sa    = {PAGE_IN[3:0], ref_addr};

  // LA20 low while blocked
  wire                  a20_block = ~GATE_A20_BLOCK_N_IN;
  wire [ADDR_MSB:LA_LSB] cpu_la   = {A_IN[ADDR_MSB:LA_BLOCK_BIT+1],
                                     A_IN[LA_BLOCK_BIT] & ~a20_block,
                                     A_IN[LA_BLOCK_BIT-1:LA_LSB]};
  wire [ADDR_MSB:LA_LSB] page_la  = dma_a[ADDR_MSB:LA_LSB];
  wire [ADDR_MSB:LA_LSB] ref_la   = ref_a[ADDR_MSB:LA_LSB];
  // slot SA lines move only on a valid access or a refresh command
  wire                  sa_load   = BUS_VALID_IN | pick_refresh;

  // local pins: driven value per mode
  always_comb begin
    next_a     = A_IN;
    next_a_top = ADDR_TOP_LOW;
    unique case (next_mode)
      MODE_CPU: begin
        next_a     = A_IN;
        next_a_top = ADDR_TOP_LOW;
      end
      MODE_DMA: begin
        next_a     = dma_a;
        next_a_top = ALT_PAGE_IN;
      end
      MODE_REFRESH: begin
        next_a     = ref_a;
        next_a_top = ALT_PAGE_IN;
      end
      MODE_MASTER: begin
        next_a     = mst_a;
        next_a_top = ADDR_TOP_LOW;
      end
    endcase
  end

  // slot lines: driven value per mode
  always_comb begin
    next_sa     = cpu_sa;
    next_sbhe_n = xif.sbhe_cpu_n;
    next_la     = cpu_la;
    unique case (next_mode)
      MODE_CPU: begin
        next_sa     = cpu_sa;
        next_sbhe_n = xif.sbhe_cpu_n;
        next_la     = cpu_la;
      end
      MODE_DMA: begin
        next_sa     = dma_sa;
        next_sbhe_n = SBHE_N_OUT;
        next_la     = page_la;
      end
      MODE_REFRESH: begin
        next_sa     = ref_sa;
        next_sbhe_n = SBHE_N_OUT;
        next_la     = ref_la;
      end
      MODE_MASTER: begin
        next_sa     = SA_OUT;
        next_sbhe_n = SBHE_N_OUT;
        next_la     = LA_OUT;
      end
    endcase
  end

  // idle high in cpu mode
  assign next_be_n = next_drives ? xif.be_drive_n : BE_IDLE_N;

  // ------------------------------------------------------------
  // local pin registers
  // ------------------------------------------------------------
  // enables follow the mode so value and enable change together
  // enables rise together
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      A_OE_OUT     <= 1'h0;
      A_TOP_OE_OUT <= 1'h0;
      BE_OE_OUT    <= 1'h0;
    end else begin
      A_OE_OUT     <= next_drives;
      A_TOP_OE_OUT <= next_drives;
      BE_OE_OUT    <= next_drives;
    end
  end

  // driven values of the local pins
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      A_OUT     <= '0;
      A_TOP_OUT <= ADDR_TOP_LOW;
      BE_N_OUT  <= BE_IDLE_N;
    end else begin
      A_OUT     <= next_a;
      A_TOP_OUT <= next_a_top;
      BE_N_OUT  <= next_be_n;
    end
  end

  // ------------------------------------------------------------
  // slot address registers
  // ------------------------------------------------------------
  // SA held between accesses to keep sensitive cards quiet
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SA_OUT     <= '0;
      SBHE_N_OUT <= 1'h1;
    end else if (sa_load) begin
      SA_OUT     <= next_sa;
      SBHE_N_OUT <= next_sbhe_n;
    end
  end

  // LA tracks the latch source every cycle
  // LA has no quiet rule
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LA_OUT <= '0;
    end else begin
      LA_OUT <= next_la;
    end
  end

  // slot drivers off while a master owns the slot bus
  // cpu, dma, refresh drive slot
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SA_OE_OUT <= 1'h1;
      LA_OE_OUT <= 1'h1;
    end else begin
      SA_OE_OUT <= (next_mode != MODE_MASTER);
      LA_OE_OUT <= (next_mode != MODE_MASTER);
    end
  end

  // ------------------------------------------------------------
  // internal io register decode
  // ------------------------------------------------------------
  // every cpu io cycle hits
  wire io_hit = (next_mode == MODE_CPU) & IO_CYCLE_IN;

  // index taken from A15-A2 only while the pins are inputs
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      IO_INDEX_OUT  <= '0;
      IO_SELECT_OUT <= 1'h0;
    end else begin
      IO_SELECT_OUT <= io_hit;
      if (io_hit) begin
        IO_INDEX_OUT <= A_IN[IO_IDX_MSB:ADDR_LSB];
      end
    end
  end

endmodule : isa_addr_port

// ---- test/isa_addr_port_props.sv ----
// checker for the cpu-side address port, bound to its top module
// assumes one clock domain and the registered timing of the port
`timescale 1ns/100ps
module isa_addr_port_props
  import isa_port_pkg::*;
(
  input wire logic                         CLK_IN,
  input wire logic                         RESET_N_IN,
  input wire logic                         HOLD_ACK_IN,
  input wire logic                         BUS_MASTER_IN,
  input wire logic                         REFRESH_CMD_IN,
  input wire logic                         GATE_A20_BLOCK_N_IN,
  input wire logic                         BUS_VALID_IN,
  input wire logic                         IO_CYCLE_IN,
  input wire logic [ADDR_MSB:ADDR_LSB]     A_IN,
  input wire logic [ADDR_MSB:ADDR_LSB]     A_OUT,
  input wire logic                         A_OE_OUT,
  input wire logic [1:0]                   A_TOP_OUT,
  input wire logic                         A_TOP_OE_OUT,
  input wire logic                         BE_OE_OUT,
  input wire logic [PAGE_WIDTH-1:0]        PAGE_IN,
  input wire logic [1:0]                   ALT_PAGE_IN,
  input wire logic [DMA_WIDTH-1:0]         DMA_ADDR_IN,
  input wire logic [SA_WIDTH-1:0]          SA_IN,
  input wire logic [ADDR_MSB:LA_LSB]       LA_IN,
  input wire logic [SA_WIDTH-1:0]          SA_OUT,
  input wire logic                         SBHE_N_OUT,
  input wire logic                         SA_OE_OUT,
  input wire logic [ADDR_MSB:LA_LSB]       LA_OUT,
  input wire logic                         LA_OE_OUT,
  input wire logic [IO_IDX_MSB-ADDR_LSB:0] IO_INDEX_OUT,
  input wire logic                         IO_SELECT_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // --------------------------------------------------------------
  // pin direction by mode
  // --------------------------------------------------------------
  property p_top_oe;
    A_TOP_OE_OUT == $past(HOLD_ACK_IN);
  endproperty
  a_top_oe: assert property (p_top_oe) else $error("top enable wrong");
  property p_oe_tie;
    A_OE_OUT == A_TOP_OE_OUT && BE_OE_OUT == A_TOP_OE_OUT;
  endproperty
  a_oe_tie: assert property (p_oe_tie) else $error("pin enables differ");
  property p_slot_oe;
    SA_OE_OUT == !$past(HOLD_ACK_IN && BUS_MASTER_IN && !REFRESH_CMD_IN)
      && LA_OE_OUT == SA_OE_OUT;
  endproperty
  a_slot_oe: assert property (p_slot_oe) else $error("slot enable wrong");

  // --------------------------------------------------------------
  // address sources
  // --------------------------------------------------------------
  property p_master;
    $past(HOLD_ACK_IN && BUS_MASTER_IN && !REFRESH_CMD_IN) |->
      A_TOP_OUT == 2'h0 && A_OUT == $past({LA_IN, SA_IN[16:2]});
  endproperty
  a_master: assert property (p_master) else $error("master address wrong");
  property p_dma;
    $past(HOLD_ACK_IN && !REFRESH_CMD_IN && !BUS_MASTER_IN) |->
      A_OUT == $past({PAGE_IN, DMA_ADDR_IN[15:2]}) && A_TOP_OUT == $past(ALT_PAGE_IN);
  endproperty
  a_dma: assert property (p_dma) else $error("dma address wrong");
  property p_refresh;
    $past(HOLD_ACK_IN && REFRESH_CMD_IN) |-> A_OUT[23:16] == $past(PAGE_IN)
      && SA_OUT[19:16] == $past(PAGE_IN[3:0]) && A_TOP_OUT == $past(ALT_PAGE_IN);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh address wrong");

  // --------------------------------------------------------------
  // cpu mode forwarding and bus quiet
  // --------------------------------------------------------------
  property p_quiet;
    !$past(BUS_VALID_IN) && !$past(HOLD_ACK_IN && REFRESH_CMD_IN) |->
      $stable(SA_OUT) && $stable(SBHE_N_OUT);
  endproperty
  a_quiet: assert property (p_quiet) else $error("slot bus moved while idle");
  property p_a20;
    $past(!HOLD_ACK_IN && BUS_VALID_IN && !GATE_A20_BLOCK_N_IN) |-> !LA_OUT[LA_BLOCK_BIT];
  endproperty
  a_a20: assert property (p_a20) else $error("blocked bit not low");
  property p_cpu_fwd;
    $past(!HOLD_ACK_IN && BUS_VALID_IN && GATE_A20_BLOCK_N_IN) |->
      LA_OUT == $past(A_IN[23:17]) && SA_OUT[19:2] == $past(A_IN[19:2]);
  endproperty
  a_cpu_fwd: assert property (p_cpu_fwd) else $error("cpu address not forwarded");
  property p_io;
    $past(!HOLD_ACK_IN && IO_CYCLE_IN) |->
      IO_SELECT_OUT && IO_INDEX_OUT == $past(A_IN[15:2]);
  endproperty
  a_io: assert property (p_io) else $error("io decode wrong");

  // main scenarios seen
  c_master: cover property (A_TOP_OE_OUT && !SA_OE_OUT);
  c_driven: cover property (A_TOP_OE_OUT && SA_OE_OUT);
  c_io: cover property (IO_SELECT_OUT);
endmodule : isa_addr_port_props

// ---- test/slot_model.sv ----
// cpu and slot side of the port: resolves each shared pin
// assumes the bench sets what cpu and slot master drive
`timescale 1ns/100ps
module slot_model
  import isa_port_pkg::*;
(
  input  wire logic [ADDR_MSB:ADDR_LSB] a_drv_in,
  input  wire logic                     a_oe_in,
  input  wire logic [3:0]               be_drv_in,
  input  wire logic                     be_oe_in,
  input  wire logic [SA_WIDTH-1:0]      sa_drv_in,
  input  wire logic                     sbhe_drv_in,
  input  wire logic                     sa_oe_in,
  input  wire logic [ADDR_MSB:LA_LSB]   la_drv_in,
  input  wire logic                     la_oe_in,
  input  wire logic [ADDR_MSB:ADDR_LSB] cpu_a_in,
  input  wire logic [3:0]               cpu_be_in,
  input  wire logic [SA_WIDTH-1:0]      m_sa_in,
  input  wire logic                     m_sbhe_in,
  input  wire logic [ADDR_MSB:LA_LSB]   m_la_in,
  output logic      [ADDR_MSB:ADDR_LSB] a_out,
  output logic      [3:0]               be_out,
  output logic      [SA_WIDTH-1:0]      sa_out,
  output logic                          sbhe_out,
  output logic      [ADDR_MSB:LA_LSB]   la_out
);
  // cpu drives the local pins unless the port does
  assign a_out = a_oe_in ? a_drv_in : cpu_a_in;
  assign be_out = be_oe_in ? be_drv_in : cpu_be_in;
  // slot master owns SA/LA only while the port lets go
  assign sa_out = sa_oe_in ? sa_drv_in : m_sa_in;
  assign sbhe_out = sa_oe_in ? sbhe_drv_in : m_sbhe_in;
  assign la_out = la_oe_in ? la_drv_in : m_la_in;
endmodule : slot_model

// ---- test/tb_top.sv ----
// self-checking bench for the cpu-side address port
// assumes the slot model resolves pins and the checker is bound
`timescale 1ns/100ps
module tb_top;
  import isa_port_pkg::*;
  typedef struct {int due; int k; logic [31:0] v;} note_t;
  localparam logic [3:0] BE_T [5] = '{4'hB, 4'h3, 4'hE, 4'h0, 4'h7};
  localparam logic [2:0] SX_T [5] = '{3'h5, 3'h4, 3'h1, 3'h0, 3'h6};
  localparam logic [2:0] DR_T [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  localparam logic [3:0] BD_T [6] = '{4'hC, 4'h3, 4'hE, 4'hB, 4'hD, 4'h7};
  string nm [11] = '{"a", "top", "oe", "sa", "sbhe", "la", "io", "be", "apage", "be16", "sadec"};
  logic CLK_IN, RESET_N_IN, HOLD_ACK_IN, BUS_MASTER_IN, REFRESH_CMD_IN;
  logic CPU_TYPE_STRAP_IN, GATE_A20_BLOCK_N_IN, BUS_VALID_IN, IO_CYCLE_IN;
  logic [ADDR_MSB:ADDR_LSB] A_IN, A_OUT, cpu_a;
  logic A_OE_OUT, A_TOP_OE_OUT, BE_OE_OUT, SBHE_N_IN, SBHE_N_OUT, SA_OE_OUT, LA_OE_OUT;
  logic IO_SELECT_OUT, m_sbhe;
  logic [1:0] A_TOP_OUT, ALT_PAGE_IN;
  logic [3:0] BE_N_IN, BE_N_OUT, cpu_be;
  logic [PAGE_WIDTH-1:0] PAGE_IN;
  logic [DMA_WIDTH-1:0] DMA_ADDR_IN;
  logic [SA_WIDTH-1:0] SA_IN, SA_OUT, m_sa, last;
  logic [ADDR_MSB:LA_LSB] LA_IN, LA_OUT, m_la;
  logic [IO_IDX_MSB-ADDR_LSB:0] IO_INDEX_OUT;
  int cyc = 0;
  int error_cnt = 0;
  int num_checks = 0;
  int i;
  note_t q [$];
  note_t nt;

  isa_addr_port dut (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .HOLD_ACK_IN(HOLD_ACK_IN),
    .BUS_MASTER_IN(BUS_MASTER_IN), .REFRESH_CMD_IN(REFRESH_CMD_IN),
    .CPU_TYPE_STRAP_IN(CPU_TYPE_STRAP_IN), .GATE_A20_BLOCK_N_IN(GATE_A20_BLOCK_N_IN),
    .BUS_VALID_IN(BUS_VALID_IN), .IO_CYCLE_IN(IO_CYCLE_IN), .A_IN(A_IN), .A_OUT(A_OUT),
    .A_OE_OUT(A_OE_OUT), .A_TOP_OUT(A_TOP_OUT), .A_TOP_OE_OUT(A_TOP_OE_OUT),
    .BE_N_IN(BE_N_IN), .BE_N_OUT(BE_N_OUT), .BE_OE_OUT(BE_OE_OUT), .PAGE_IN(PAGE_IN),
    .ALT_PAGE_IN(ALT_PAGE_IN), .DMA_ADDR_IN(DMA_ADDR_IN), .SA_IN(SA_IN),
    .SBHE_N_IN(SBHE_N_IN), .LA_IN(LA_IN), .SA_OUT(SA_OUT), .SBHE_N_OUT(SBHE_N_OUT),
    .SA_OE_OUT(SA_OE_OUT), .LA_OUT(LA_OUT), .LA_OE_OUT(LA_OE_OUT),
    .IO_INDEX_OUT(IO_INDEX_OUT), .IO_SELECT_OUT(IO_SELECT_OUT));
  slot_model model (.a_drv_in(A_OUT), .a_oe_in(A_OE_OUT), .be_drv_in(BE_N_OUT),
    .be_oe_in(BE_OE_OUT), .sa_drv_in(SA_OUT), .sbhe_drv_in(SBHE_N_OUT), .sa_oe_in(SA_OE_OUT),
    .la_drv_in(LA_OUT), .la_oe_in(LA_OE_OUT), .cpu_a_in(cpu_a), .cpu_be_in(cpu_be),
    .m_sa_in(m_sa), .m_sbhe_in(m_sbhe), .m_la_in(m_la), .a_out(A_IN), .be_out(BE_N_IN),
    .sa_out(SA_IN), .sbhe_out(SBHE_N_IN), .la_out(LA_IN));

  // --------------------------------------------------------------
  // clock, cycle count and helpers
  // --------------------------------------------------------------
  always #2 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) cyc <= cyc + 1;
  task automatic tick(int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask : tick
  // note an expectation due two edges after the current inputs
  task automatic put(int k, logic [31:0] v);
    q.push_back('{cyc + 2, k, v});
  endtask : put
  function automatic logic [31:0] obs(int k);
    case (k)
      0: obs = 32'(A_OUT);
      1: obs = 32'(A_TOP_OUT);
      2: obs = 32'({A_OE_OUT, A_TOP_OE_OUT, BE_OE_OUT, SA_OE_OUT});
      3: obs = 32'(SA_OUT);
      4: obs = 32'(SBHE_N_OUT);
      5: obs = 32'(LA_OUT);
      6: obs = 32'(IO_INDEX_OUT);
      7: obs = 32'(BE_N_OUT);
      8: obs = 32'(A_OUT[23:16]);
      9: obs = 32'(BE_N_OUT[2:0]);
      default: obs = 32'({SA_OUT[1:0], SBHE_N_OUT});
    endcase
  endfunction : obs
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // monitor: every due note, oldest first, against the settled outputs
  always @(negedge CLK_IN) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      nt = q.pop_front();
      chk(nm[nt.k], nt.v, obs(nt.k));
    end
  end

  // --------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------
  initial begin
    {CLK_IN, RESET_N_IN, HOLD_ACK_IN, BUS_MASTER_IN, REFRESH_CMD_IN} = 5'h0;
    {CPU_TYPE_STRAP_IN, GATE_A20_BLOCK_N_IN, BUS_VALID_IN, IO_CYCLE_IN} = 4'hC;
    {cpu_a, cpu_be, PAGE_IN, ALT_PAGE_IN, DMA_ADDR_IN, m_sa, m_la, m_sbhe} = '0;
    void'($urandom(62331));
    tick(20);
    RESET_N_IN = 1'h1;
    put(2, 4'h1);
    put(7, 4'hF);
    tick(2);
    // cpu mode, 16-bit pins, a20 block both ways
    for (i = 0; i < 4; i++) begin
      cpu_a = 22'($urandom());
      cpu_be = 4'($urandom());
      {GATE_A20_BLOCK_N_IN, BUS_VALID_IN, IO_CYCLE_IN} = {i[0], 2'h3};
      put(3, {cpu_a[19:2], cpu_be[2], cpu_be[0]});
      put(4, cpu_be[1]);
      put(5, {cpu_a[23:21], cpu_a[20] & i[0], cpu_a[19:17]});
      put(6, cpu_a[15:2]);
      put(2, 4'h1);
      tick(2);
    end
    // bus quiet: address moves, slot bus must not
    last = {cpu_a[19:2], cpu_be[2], cpu_be[0]};
    {BUS_VALID_IN, IO_CYCLE_IN} = 2'h0;
    cpu_a = ~cpu_a;
    put(3, last);
    tick(2);
    // dma, refresh and master back to back
    for (i = 0; i < 3; i++) begin
      {PAGE_IN, ALT_PAGE_IN, DMA_ADDR_IN} = 26'($urandom());
      {m_sa, m_la, m_sbhe} = 28'($urandom());
      {HOLD_ACK_IN, REFRESH_CMD_IN, BUS_MASTER_IN} = {1'h1, i == 1, i == 2};
      put(2, (i == 2) ? 4'hE : 4'hF);
      put(1, (i == 2) ? 2'h0 : ALT_PAGE_IN);
      if (i == 0) put(0, {PAGE_IN, DMA_ADDR_IN[15:2]});
      if (i == 1) put(8, PAGE_IN);
      if (i == 2) put(0, {m_la, m_sa[16:2]});
      if (i == 2) put(9, {m_sa[1], m_sbhe, m_sa[0]});
      tick(2);
    end
    // second reset in 32-bit byte-enable mode
    tick(1);
    {RESET_N_IN, HOLD_ACK_IN, BUS_MASTER_IN, CPU_TYPE_STRAP_IN} = 4'h0;
    tick(3);
    RESET_N_IN = 1'h1;
    BUS_VALID_IN = 1'h1;
    tick(1);
    for (i = 0; i < 5; i++) begin
      cpu_be = BE_T[i];
      put(10, SX_T[i]);
      tick(2);
    end
    {HOLD_ACK_IN, BUS_MASTER_IN} = 2'h3;
    for (i = 0; i < 6; i++) begin
      {m_sa[1:0], m_sbhe} = {DR_T[i][2], DR_T[i][1], DR_T[i][0]};
      put(7, BD_T[i]);
      tick(2);
    end
    for (i = 0; i < 20 && q.size() > 0; i++) tick(1);
    if (q.size() > 0) error_cnt++;
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (2000) @(posedge CLK_IN);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top

bind isa_addr_port isa_addr_port_props u_props (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .HOLD_ACK_IN(HOLD_ACK_IN), .BUS_MASTER_IN(BUS_MASTER_IN), .REFRESH_CMD_IN(REFRESH_CMD_IN),
  .GATE_A20_BLOCK_N_IN(GATE_A20_BLOCK_N_IN), .BUS_VALID_IN(BUS_VALID_IN),
  .IO_CYCLE_IN(IO_CYCLE_IN), .A_IN(A_IN), .A_OUT(A_OUT), .A_OE_OUT(A_OE_OUT),
  .A_TOP_OUT(A_TOP_OUT), .A_TOP_OE_OUT(A_TOP_OE_OUT), .BE_OE_OUT(BE_OE_OUT),
  .PAGE_IN(PAGE_IN), .ALT_PAGE_IN(ALT_PAGE_IN), .DMA_ADDR_IN(DMA_ADDR_IN), .SA_IN(SA_IN),
  .LA_IN(LA_IN), .SA_OUT(SA_OUT), .SBHE_N_OUT(SBHE_N_OUT), .SA_OE_OUT(SA_OE_OUT),
  .LA_OUT(LA_OUT), .LA_OE_OUT(LA_OE_OUT), .IO_INDEX_OUT(IO_INDEX_OUT),
  .IO_SELECT_OUT(IO_SELECT_OUT));
